// file: src/pwmt_pkg.sv
// package: register map, field layout and types of the pwm unit
package pwmt_pkg;

  localparam int ADR_W = 8;
  localparam int CNT_W = 16;
  localparam int EVT_W = 6;

  localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_PERIOD = 8'h04;
  localparam logic [ADR_W-1:0] OFS_CMP = 8'h08;
  localparam logic [ADR_W-1:0] OFS_DEAD = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_ISTAT = 8'h10;
  localparam logic [ADR_W-1:0] OFS_IMASK = 8'h14;
  localparam logic [ADR_W-1:0] OFS_ADCSEL = 8'h18;
  localparam logic [ADR_W-1:0] OFS_STAT = 8'h1C;

  // event bit positions, shared by status, mask and adc select
  localparam int EV_PRD = 0;
  localparam int EV_ZERO = 1;
  localparam int EV_CUP = 2;
  localparam int EV_CDN = 3;
  localparam int EV_CBC = 4;
  localparam int EV_OST = 5;

  localparam int DEAD_FALL_LSB = 16;
  localparam int ST_DIR = 16;
  localparam int ST_OST = 17;
  localparam int ST_CBC = 18;

  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'h00FF;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [31:0] DEAD_RST = 32'h0000_0000;

  typedef enum logic [1:0] {MODE_UP, MODE_DOWN, MODE_UPDN, MODE_STOP} pwmtMode_t;
  typedef enum logic [1:0] {LD_ZERO, LD_PERIOD, LD_BOTH, LD_NOW} pwmtLoad_t;
  typedef enum logic [1:0] {BLK_HIZ, BLK_HIGH, BLK_LOW} pwmtBlk_t;

  typedef struct packed {
    logic dbEn;
    pwmtBlk_t blkB;
    pwmtBlk_t blkA;
    logic filtEn;
    logic cbcEn;
    logic ostEn;
    logic complEn;
    logic forceLvl;
    logic forceEn;
    pwmtLoad_t loadSel;
    pwmtMode_t mode;
    logic run;
  } pwmtCtrl_t;

  typedef struct packed {
    logic [ADR_W-1:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
  } pwmtBusReq_t;

endpackage : pwmt_pkg

// file: src/pwmt_deadband.sv
// dead-band stage: separate rising and falling edge delays
`timescale 1ns/100ps
module pwmt_deadband #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // waveform and delays in clock cycles
  input wire logic wave,
  input wire logic [W-1:0] riseDly,
  input wire logic [W-1:0] fallDly,
  // delayed waveforms
  output logic riseOut,
  output logic fallOut
);

  logic wavePrev_q;
  logic [W-1:0] riseCnt_q;
  logic [W-1:0] fallCnt_q;
  logic edgeSeen;
  logic riseDone;
  logic fallDone;

  assign edgeSeen = wave != wavePrev_q;
  assign riseDone = edgeSeen ? (riseDly == '0) : (riseCnt_q <= W'(1));
  assign fallDone = edgeSeen ? (fallDly == '0) : (fallCnt_q <= W'(1));

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wavePrev_q <= 1'b0;
      riseCnt_q <= '0;
      fallCnt_q <= '0;
    end else if (ce) begin
      wavePrev_q <= wave;
      if (edgeSeen) begin
        riseCnt_q <= riseDly;
        fallCnt_q <= fallDly;
      end else begin
        if (riseCnt_q != '0) begin
          riseCnt_q <= riseCnt_q - W'(1);
        end
        if (fallCnt_q != '0) begin
          fallCnt_q <= fallCnt_q - W'(1);
        end
      end
    end
  end

  // short pulses narrower than the delay vanish on that path
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      riseOut <= 1'b0;
      fallOut <= 1'b0;
    end else if (ce) begin
      riseOut <= wave & riseDone;
      fallOut <= wave | ~fallDone;
    end
  end

endmodule : pwmt_deadband

// file: src/pwmt_top.sv
// pwm unit: time base, compare, action, dead band, trip, events
// Behaviour
// - sixteen-bit time-base counter, period set by a software register.
// - up-down mode: output high on rising match, low on falling match.
// - up-down period lasts twice the period value in clock cycles.
// - up-down duty is one minus the ratio of compare value to period value.
// - counter equal to period raises an interrupt event when enabled.
// - compare writes go to a shadow, loaded at a selectable point.
// - software can force the output level, overriding compare actions.
// - dead band delays rising and falling edges by separate amounts.
// - second output is the fall-delayed waveform, inverted only while complEn is set; only then never both on while not blocked.
// - a fault blocks outputs per cycle or one-shot, as configured.
// - while blocked each output is high, low or high impedance.
// - compare results or trip inputs block raw or after filtering.
// - any event can drive the interrupt or an adc start request.
// - per-cycle blocking releases itself at the next period start.
// - one-shot blocking holds until software clears its flag.
// - one-shot blocking wins when both kinds assert together.
`timescale 1ns/100ps
module pwmt_top #(
  parameter int FILT_LEN = 4
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [pwmt_pkg::ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // fault sources
  input wire logic [1:0] tripIn,
  input wire logic dcEvt,
  // power stage outputs
  output logic pwmAOut,
  output logic pwmAOe,
  output logic pwmBOut,
  output logic pwmBOe,
  // system
  output logic irq,
  output logic adcReq
);

  localparam int FW = $clog2(FILT_LEN + 1);

  pwmt_pkg::pwmtCtrl_t ctrl_q;
  pwmt_pkg::pwmtBusReq_t req;
  logic [15:0] period_q;
  logic [15:0] cmpShadow_q;
  logic [15:0] cmpAct_q;
  logic [31:0] dead_q;
  logic [pwmt_pkg::EVT_W-1:0] istat_q;
  logic [pwmt_pkg::EVT_W-1:0] imask_q;
  logic [pwmt_pkg::EVT_W-1:0] adcSel_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic dirDown_q;
  logic dirDown_d;
  logic act_q;
  logic [1:0] tripMeta_q;
  logic [1:0] tripSync_q;
  logic [FW-1:0] filt_q;
  logic ost_q;
  logic cbc_q;
  logic ack_q;
  logic [31:0] rdVal;
  logic [31:0] wrVal;
  logic wrEn;
  logic statRead;
  logic ostClr;
  logic ticking;
  logic atPrd;
  logic atZero;
  logic cmpHit;
  logic rawFault;
  logic fault;
  logic cbcSet;
  logic ostSet;
  logic blocked;
  logic redOut;
  logic fedOut;
  logic preB;
  logic [pwmt_pkg::EVT_W-1:0] evt;
  logic [15:0] riseDly;
  logic [15:0] fallDly;

  // merges byte lanes of a write into the current register value
  function automatic logic [31:0] pwmtMerge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : pwmtMerge

  // blocked pin level: {oe, out}
  function automatic logic [1:0] pwmtBlock(input pwmt_pkg::pwmtBlk_t st,
                                           input logic pre,
                                           input logic blk);
    logic [1:0] res;
    res = {1'b1, pre};
    if (blk) begin
      case (st)
        pwmt_pkg::BLK_HIGH: res = 2'b11;
        pwmt_pkg::BLK_LOW: res = 2'b10;
        default: res = 2'b00;
      endcase
    end
    return res;
  endfunction : pwmtBlock

  ////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the request, writes on ack
  assign req = '{adr: adr_i, dat: dat_i, sel: sel_i, we: we_i};
  assign ack_o = ack_q;
  assign wrEn = cyc_i & stb_i & req.we & ack_q;
  assign statRead = cyc_i & stb_i & ~req.we & ack_q & (req.adr == pwmt_pkg::OFS_ISTAT);
  assign ostClr = wrEn & (req.adr == pwmt_pkg::OFS_STAT) & wrVal[pwmt_pkg::ST_OST];
  assign wrVal = pwmtMerge(rdVal, req.dat, req.sel);

  always_comb begin
    rdVal = 32'h0000_0000;
    case (req.adr)
      pwmt_pkg::OFS_CTRL: rdVal[15:0] = ctrl_q;
      pwmt_pkg::OFS_PERIOD: rdVal[15:0] = period_q;
      pwmt_pkg::OFS_CMP: rdVal[15:0] = cmpShadow_q;
      pwmt_pkg::OFS_DEAD: rdVal = dead_q;
      pwmt_pkg::OFS_ISTAT: rdVal[pwmt_pkg::EVT_W-1:0] = istat_q;
      pwmt_pkg::OFS_IMASK: rdVal[pwmt_pkg::EVT_W-1:0] = imask_q;
      pwmt_pkg::OFS_ADCSEL: rdVal[pwmt_pkg::EVT_W-1:0] = adcSel_q;
      pwmt_pkg::OFS_STAT: begin
        rdVal[15:0] = count_q;
        rdVal[pwmt_pkg::ST_DIR] = dirDown_q;
        rdVal[pwmt_pkg::ST_OST] = ost_q;
        rdVal[pwmt_pkg::ST_CBC] = cbc_q;
      end
      default: rdVal = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce) begin
      ack_q <= cyc_i & stb_i & ~ack_q;
      dat_o <= rdVal;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= pwmt_pkg::pwmtCtrl_t'(pwmt_pkg::CTRL_RST);
      period_q <= pwmt_pkg::PERIOD_RST;
      cmpShadow_q <= pwmt_pkg::CMP_RST;
      dead_q <= pwmt_pkg::DEAD_RST;
      imask_q <= '0;
      adcSel_q <= '0;
    end else if (ce && wrEn) begin
      case (req.adr)
        pwmt_pkg::OFS_CTRL: ctrl_q <= pwmt_pkg::pwmtCtrl_t'(wrVal[15:0]);
        pwmt_pkg::OFS_PERIOD: period_q <= wrVal[15:0];
        pwmt_pkg::OFS_CMP: cmpShadow_q <= wrVal[15:0];
        pwmt_pkg::OFS_DEAD: dead_q <= wrVal;
        pwmt_pkg::OFS_IMASK: imask_q <= wrVal[pwmt_pkg::EVT_W-1:0];
        pwmt_pkg::OFS_ADCSEL: adcSel_q <= wrVal[pwmt_pkg::EVT_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // time base
  assign ticking = ce & ctrl_q.run;
  assign atPrd = count_q >= period_q;
  assign atZero = count_q == 16'h0000;

  always_comb begin
    count_d = count_q;
    dirDown_d = dirDown_q;
    case (ctrl_q.mode)
      pwmt_pkg::MODE_UP: begin
        dirDown_d = 1'b0;
        count_d = atPrd ? 16'h0000 : count_q + 16'h0001;
      end
      pwmt_pkg::MODE_DOWN: begin
        dirDown_d = 1'b1;
        count_d = atZero ? period_q : count_q - 16'h0001;
      end
      pwmt_pkg::MODE_UPDN: begin
        // climb to the period, then return: two period values per cycle
        if (period_q == 16'h0000) begin
          count_d = 16'h0000;
        end else if (!dirDown_q) begin
          dirDown_d = atPrd;
          count_d = atPrd ? period_q - 16'h0001 : count_q + 16'h0001;
        end else begin
          dirDown_d = ~atZero;
          count_d = atZero ? 16'h0001 : count_q - 16'h0001;
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 16'h0000;
      dirDown_q <= 1'b0;
    end else if (ticking) begin
      count_q <= count_d;
      dirDown_q <= dirDown_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // compare with shadow load
  assign cmpHit = count_q == cmpAct_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmpAct_q <= pwmt_pkg::CMP_RST;
    end else if (ce) begin
      case (ctrl_q.loadSel)
        pwmt_pkg::LD_ZERO: if (ticking && atZero) cmpAct_q <= cmpShadow_q;
        pwmt_pkg::LD_PERIOD: if (ticking && atPrd) cmpAct_q <= cmpShadow_q;
        pwmt_pkg::LD_BOTH: if (ticking && (atZero || atPrd)) cmpAct_q <= cmpShadow_q;
        default: cmpAct_q <= cmpShadow_q;
      endcase
    end
  end

  // action stage; up-down high time is period minus compare, times two; up mode high time is the compare value
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_q <= 1'b0;
    end else if (ce) begin
      if (ctrl_q.forceEn) begin
        act_q <= ctrl_q.forceLvl;
      end else if (ticking && cmpHit) begin
        act_q <= (ctrl_q.mode == pwmt_pkg::MODE_UP) ? 1'b0 : ~dirDown_q;
      end else if (ticking && atZero && ctrl_q.mode == pwmt_pkg::MODE_UP) begin
        act_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // dead band and complementary pair
  assign riseDly = ctrl_q.dbEn ? dead_q[15:0] : 16'h0000;
  assign fallDly = ctrl_q.dbEn ? dead_q[pwmt_pkg::DEAD_FALL_LSB +: 16] : 16'h0000;

  pwmt_deadband #(.W(16)) u_deadband (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .wave(act_q),
    .riseDly(riseDly),
    .fallDly(fallDly),
    .riseOut(redOut),
    .fallOut(fedOut)
  );

  // inverting the fall-delayed copy keeps both switches apart
  assign preB = ctrl_q.complEn ? ~fedOut : fedOut;

  ////////////////////////////////////////////////////////////////////
  // fault path: pins synchronised, compare result same-clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tripMeta_q <= 2'b00;
      tripSync_q <= 2'b00;
    end else if (ce) begin
      tripMeta_q <= tripIn;
      tripSync_q <= tripMeta_q;
    end
  end

  assign rawFault = (|tripSync_q) | dcEvt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_q <= '0;
    end else if (ce) begin
      if (!rawFault) begin
        filt_q <= '0;
      end else if (filt_q != FW'(FILT_LEN)) begin
        filt_q <= filt_q + FW'(1);
      end
    end
  end

  assign fault = ctrl_q.filtEn ? (filt_q == FW'(FILT_LEN)) : rawFault;
  assign ostSet = fault & ctrl_q.ostEn;
  assign cbcSet = fault & ctrl_q.cbcEn & ~ost_q & ~ostSet;
  assign blocked = ost_q | cbc_q;

  // set wins over the software clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ost_q <= 1'b0;
    end else if (ce) begin
      if (ostSet) begin
        ost_q <= 1'b1;
      end else if (ostClr) begin
        ost_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cbc_q <= 1'b0;
    end else if (ce) begin
      if (cbcSet) begin
        cbc_q <= 1'b1;
      end else if (ost_q || ostSet || (ticking && atZero)) begin
        cbc_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {pwmAOe, pwmAOut} <= 2'b00;
      {pwmBOe, pwmBOut} <= 2'b00;
    end else if (ce) begin
      {pwmAOe, pwmAOut} <= pwmtBlock(ctrl_q.blkA, redOut, blocked);
      {pwmBOe, pwmBOut} <= pwmtBlock(ctrl_q.blkB, preB, blocked);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // events, sticky status, interrupt and adc request
  always_comb begin
    evt = '0;
    evt[pwmt_pkg::EV_PRD] = ticking & (count_q == period_q);
    evt[pwmt_pkg::EV_ZERO] = ticking & atZero;
    evt[pwmt_pkg::EV_CUP] = ticking & cmpHit & ~dirDown_q;
    evt[pwmt_pkg::EV_CDN] = ticking & cmpHit & dirDown_q;
    evt[pwmt_pkg::EV_CBC] = ce & cbcSet & ~cbc_q;
    evt[pwmt_pkg::EV_OST] = ce & ostSet & ~ost_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_q <= '0;
    end else if (ce) begin
      istat_q <= (statRead ? '0 : istat_q) | evt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      adcReq <= 1'b0;
    end else if (ce) begin
      adcReq <= |(evt & adcSel_q);
    end
  end

  assign irq = |(istat_q & imask_q);

  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_ack_single: assert property (ack_o && ce |=> !ack_o)
    else $error("ack stood longer than one cycle");
  a_count_bound: assert property (
    ticking && ctrl_q.mode == pwmt_pkg::MODE_UPDN && count_q < period_q
    && $stable(period_q) |=> count_q <= period_q)
    else $error("counter ran past the period");
  a_updn_turn: assert property (
    ticking && ctrl_q.mode == pwmt_pkg::MODE_UPDN && !dirDown_q
    && count_q == period_q && period_q != 16'h0000
    |=> dirDown_q && count_q == $past(period_q) - 16'h0001)
    else $error("up-down counter did not turn at the period");
  a_rise_high: assert property (
    ticking && !ctrl_q.forceEn && ctrl_q.mode == pwmt_pkg::MODE_UPDN
    && cmpHit && !dirDown_q |=> act_q)
    else $error("rising match did not drive high");
  a_fall_low: assert property (
    ticking && !ctrl_q.forceEn && ctrl_q.mode == pwmt_pkg::MODE_UPDN
    && cmpHit && dirDown_q |=> !act_q)
    else $error("falling match did not drive low");
  a_force_level: assert property (
    ce && ctrl_q.forceEn |=> act_q == $past(ctrl_q.forceLvl))
    else $error("forced level lost");
  a_shadow_zero: assert property (
    ticking && ctrl_q.loadSel == pwmt_pkg::LD_ZERO && atZero
    |=> cmpAct_q == $past(cmpShadow_q))
    else $error("shadow not loaded at zero");
  a_ost_hold: assert property (
    ost_q && !ostClr |=> ost_q)
    else $error("one-shot block released without clear");
  a_cbc_release: assert property (
    cbc_q && ticking && atZero && !cbcSet |=> !cbc_q)
    else $error("per-cycle block not released at zero");
  a_ost_first: assert property (
    ce && ostSet |=> !cbc_q ##1 1'b1)
    else $error("per-cycle block set beside one-shot");
  a_block_hiz: assert property (
    ce && blocked && ctrl_q.blkA == pwmt_pkg::BLK_HIZ |=> !pwmAOe)
    else $error("blocked output still driven");
  a_prd_sticky: assert property (
    istat_q[pwmt_pkg::EV_PRD] && !statRead |=> istat_q[pwmt_pkg::EV_PRD])
    else $error("period flag dropped without a read");
  a_no_overlap: assert property (
    ctrl_q.complEn && !blocked && pwmAOe && pwmBOe |-> !(pwmAOut && pwmBOut))
    else $error("both switches on together");

  c_ost_trip: cover property (ce && ostSet && !ost_q);
  c_cbc_release: cover property (cbc_q ##1 !cbc_q);
  c_stat_read: cover property (statRead && istat_q != '0);

endmodule : pwmt_top

// file: tb/pwmt_stage_model.sv
// power stage model: gate inputs with pull-down and overlap counter
`timescale 1ns/100ps
module pwmt_stage_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pins from the pwm unit
  input wire logic pwmAOut,
  input wire logic pwmAOe,
  input wire logic pwmBOut,
  input wire logic pwmBOe,
  // gate levels and overlap count
  output logic gateA,
  output logic gateB,
  output logic [15:0] overlapCnt
);
  // undriven gate inputs rest on their pull-down, so hi-z means off
  assign gateA = pwmAOe ? pwmAOut : 1'b0;
  assign gateB = pwmBOe ? pwmBOut : 1'b0;
  ////////////////////////////////////////////////////////////////////
  // both switches on together would short the bridge leg
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overlapCnt <= 16'h0000;
    end else if (gateA && gateB) begin
      overlapCnt <= overlapCnt + 16'h0001;
    end
  end
endmodule : pwmt_stage_model

// file: tb/tb.sv
// testbench: register bus, waveform, dead band, events and trips
`timescale 1ns/100ps
module tb;
  localparam int P = 6;
  localparam int C = 2;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic [1:0] trip = 2'b00;
  logic dcEvt = 1'b0;
  logic [31:0] rdat;
  logic ack, pwmAOut, pwmAOe, pwmBOut, pwmBOe, irq, adcReq, gateA, gateB;
  logic [15:0] overlapCnt;
  logic [31:0] q;
  int errorCnt = 0;
  int totalChecks = 0;
  int hi;
  pwmt_pkg::pwmtCtrl_t ctl = '0;

  always #12.5 sys_clk = ~sys_clk;

  pwmt_top #(.FILT_LEN(2)) pwmt_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(sel),
    .dat_o(rdat), .ack_o(ack), .tripIn(trip), .dcEvt(dcEvt), .pwmAOut(pwmAOut),
    .pwmAOe(pwmAOe), .pwmBOut(pwmBOut), .pwmBOe(pwmBOe), .irq(irq), .adcReq(adcReq));
  pwmt_stage_model pwmt_stage_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .pwmAOut(pwmAOut), .pwmAOe(pwmAOe), .pwmBOut(pwmBOut), .pwmBOe(pwmBOe),
    .gateA(gateA), .gateB(gateB), .overlapCnt(overlapCnt));

  ////////////////////////////////////////////////////////////////////
  task automatic finalReport();
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finalReport

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic hang();
    errorCnt++;
    $display("[FAIL] %0t wait ran out", $time);
    finalReport();
  endtask : hang

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // classic single cycle; ack and read data taken at the same edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    int n;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) hang();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic setCtl();
    wb(pwmt_pkg::OFS_CTRL, 1'b1, {16'h0000, ctl});
  endtask : setCtl

  function automatic logic probe(input int i);
    case (i)
      0: return gateA;
      1: return gateB;
      2: return irq;
      default: return adcReq;
    endcase
  endfunction : probe

  task automatic waitLvl(input int i, input logic v);
    int n;
    n = 0;
    while (probe(i) !== v && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    if (probe(i) !== v) hang();
  endtask : waitLvl

  // second pulse only: the first may still carry an old compare value
  task automatic measure(input int i, output int h);
    repeat (2) begin
      waitLvl(i, 1'b0);
      waitLvl(i, 1'b1);
      h = 0;
      while (probe(i) === 1'b1 && h < 200) begin
        @(posedge sys_clk);
        h++;
      end
    end
  endtask : measure

  ////////////////////////////////////////////////////////////////////
  task automatic scnRegs();
    wb(pwmt_pkg::OFS_PERIOD, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_00FF);
    wb(pwmt_pkg::OFS_DEAD, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    wb(pwmt_pkg::OFS_PERIOD, 1'b1, 32'h0000_1234, 4'h1);
    wb(pwmt_pkg::OFS_PERIOD, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0034);
    wb(8'h40, 1'b1, 32'hFFFF_FFFF);
    wb(8'h40, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    wb(pwmt_pkg::OFS_ISTAT, 1'b1, 32'h0000_003F);
    wb(pwmt_pkg::OFS_ISTAT, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
  endtask : scnRegs

  task automatic scnWave();
    int n;
    wb(pwmt_pkg::OFS_PERIOD, 1'b1, P);
    wb(pwmt_pkg::OFS_CMP, 1'b1, C);
    ctl.run = 1'b1;
    ctl.mode = pwmt_pkg::MODE_UPDN;
    ctl.complEn = 1'b1;
    setCtl();
    measure(0, hi);
    chk(hi, 2 * (P - C));
    // low time measured on its own, so the period is not taken on trust
    n = 0;
    while (gateA === 1'b0 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk(hi + n, 2 * P);
    measure(1, hi);
    chk(hi, 2 * C);
  endtask : scnWave

  // every load point, alternating compare values
  task automatic scnLoad();
    int cv;
    for (int l = 0; l < 4; l++) begin
      cv = (l % 2) ? 1 : 3;
      ctl.loadSel = pwmt_pkg::pwmtLoad_t'(l);
      setCtl();
      wb(pwmt_pkg::OFS_CMP, 1'b1, cv);
      wb(pwmt_pkg::OFS_CMP, 1'b0, 32'h0000_0000);
      chk(q, cv);
      measure(0, hi);
      chk(hi, 2 * (P - cv));
    end
    wb(pwmt_pkg::OFS_CMP, 1'b1, C);
  endtask : scnLoad

  task automatic scnDead();
    wb(pwmt_pkg::OFS_DEAD, 1'b1, 32'h0002_0001);
    ctl.dbEn = 1'b1;
    setCtl();
    measure(0, hi);
    chk(hi, 2 * (P - C) - 1);
    measure(1, hi);
    chk(hi, 2 * C - 2);
    ctl.dbEn = 1'b0;
  endtask : scnDead

  task automatic scnForce();
    ctl.forceEn = 1'b1;
    for (int v = 0; v < 2; v++) begin
      ctl.forceLvl = v[0];
      setCtl();
      tick(6);
      for (int k = 0; k < 2 * P; k++) begin
        tick(1);
        chk({gateA, gateB}, {v[0], ~v[0]});
      end
    end
    ctl.forceEn = 1'b0;
    setCtl();
  endtask : scnForce

  task automatic scnEvents();
    int n;
    wb(pwmt_pkg::OFS_IMASK, 1'b1, 32'h0000_0001);
    // old flags cleared, so irq marks a fresh period event
    wb(pwmt_pkg::OFS_ISTAT, 1'b0, 32'h0000_0000);
    tick(1);
    waitLvl(2, 1'b1);
    wb(pwmt_pkg::OFS_IMASK, 1'b1, 32'h0000_0000);
    tick(1);
    chk(irq, 1'b0);
    wb(pwmt_pkg::OFS_ISTAT, 1'b0, 32'h0000_0000);
    chk(q[pwmt_pkg::EV_PRD], 1'b1);
    wb(pwmt_pkg::OFS_ISTAT, 1'b0, 32'h0000_0000);
    chk(q[pwmt_pkg::EV_PRD], 1'b0);
    wb(pwmt_pkg::OFS_ADCSEL, 1'b1, 32'h0000_0002);
    waitLvl(3, 1'b1);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (adcReq !== 1'b1 && n < 100);
    chk(n, 2 * P);
    wb(pwmt_pkg::OFS_ADCSEL, 1'b1, 32'h0000_0000);
  endtask : scnEvents

  task automatic scnTrip();
    ctl.ostEn = 1'b1;
    ctl.blkA = pwmt_pkg::BLK_LOW;
    ctl.blkB = pwmt_pkg::BLK_HIZ;
    setCtl();
    trip <= 2'b01;
    tick(3);
    trip <= 2'b00;
    tick(8 + 6 * P);
    chk({pwmAOe, pwmAOut, pwmBOe}, 3'b100);
    wb(pwmt_pkg::OFS_STAT, 1'b1, 32'h0002_0000);
    tick(2 * P + 4);
    chk({pwmAOe, pwmBOe}, 2'b11);
    ctl.ostEn = 1'b0;
    ctl.cbcEn = 1'b1;
    ctl.blkA = pwmt_pkg::BLK_HIGH;
    ctl.blkB = pwmt_pkg::BLK_LOW;
    setCtl();
    dcEvt <= 1'b1;
    tick(4);
    chk({pwmAOe, pwmAOut, pwmBOe, pwmBOut}, 4'b1110);
    dcEvt <= 1'b0;
    tick(2 * P + 4);
    wb(pwmt_pkg::OFS_STAT, 1'b0, 32'h0000_0000);
    chk(q[pwmt_pkg::ST_CBC], 1'b0);
    measure(0, hi);
    chk(hi, 2 * (P - C));
    // a pulse shorter than the filter must leave no per-cycle event
    wb(pwmt_pkg::OFS_ISTAT, 1'b0, 32'h0000_0000);
    ctl.filtEn = 1'b1;
    setCtl();
    dcEvt <= 1'b1;
    tick(1);
    dcEvt <= 1'b0;
    tick(4);
    wb(pwmt_pkg::OFS_ISTAT, 1'b0, 32'h0000_0000);
    chk(q[pwmt_pkg::EV_CBC], 1'b0);
    ctl.ostEn = 1'b1;
    ctl.blkA = pwmt_pkg::BLK_HIZ;
    setCtl();
    dcEvt <= 1'b1;
    tick(4);
    dcEvt <= 1'b0;
    wb(pwmt_pkg::OFS_STAT, 1'b0, 32'h0000_0000);
    chk({q[pwmt_pkg::ST_OST], q[pwmt_pkg::ST_CBC]}, 2'b10);
    chk(pwmAOe, 1'b0);
    wb(pwmt_pkg::OFS_STAT, 1'b1, 32'h0002_0000);
  endtask : scnTrip

  ////////////////////////////////////////////////////////////////////
  initial begin
    tick(8);
    rst_n <= 1'b1;
    tick(2);
    scnRegs();
    scnWave();
    scnLoad();
    scnDead();
    scnForce();
    scnEvents();
    scnTrip();
    chk(overlapCnt, 16'h0000);
    finalReport();
  end
endmodule : tb
